/* File: design/pmrpw_bank.sv */
// Result, peak-hold and warning-limit register bank of a current and power monitor.
// Assumes the serial bus engine and conversion front end run on clk.
`timescale 1ns/1ps
`default_nettype none
module pmrpw_bank
  import pmrpw_pkg::*;
#(
  parameter int WARN_TICK_CYCLES = WARN_STEP_CYCLES
) (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Conversion results
  input  wire logic        result_valid,
  input  wire logic [15:0] shunt_result,
  input  wire logic [15:0] bus_result,
  // Register port from the serial bus engine
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr_en,
  input  wire logic [15:0] reg_wr_data,
  input  wire logic        reg_rd_en,
  output logic [15:0]      reg_rd_data,
  // Warning control and status
  input  wire logic        warn_output_enable,
  input  wire logic        flag_clear,
  output logic             shunt_high_warn_flag,
  output logic             shunt_low_warn_flag,
  output logic             power_warn_flag,
  output logic             bus_high_warn_flag,
  output logic             bus_low_warn_flag,
  // Open-collector warning pin
  output logic             warn_pin_out,
  output logic             warn_pin_oe
);
  if (WARN_TICK_CYCLES < 1) begin : g_tick_check
    $error("WARN_TICK_CYCLES must be at least one");
  end

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  function automatic logic [15:0] calc_current(input logic [15:0] shunt,
                                               input logic [15:0] cal);
    logic signed [32:0] prod;
    logic signed [32:0] quot;
    prod = $signed({{17{shunt[15]}}, shunt}) * $signed({17'h0, cal & CAL_MASK});
    quot = prod >>> CURRENT_SHIFT;
    // Saturate rather than wrap so the sign never flips on overflow
    if (quot > 33'sd32767) begin
      calc_current = 16'h7FFF;
    end else if (quot < -33'sd32768) begin
      calc_current = 16'h8000;
    end else begin
      calc_current = quot[15:0];
    end
  endfunction : calc_current

  function automatic logic [15:0] calc_power(input logic [15:0] cur,
                                             input logic [15:0] bus);
    logic [16:0] mag;
    logic [29:0] prod;
    logic [29:0] quot;
    mag  = cur[15] ? (17'h0 - {cur[15], cur}) : {1'b0, cur};
    prod = 30'(mag) * 30'(bus[15:BUS_FIELD_LSB]);
    quot = prod / POWER_DIVISOR;
    calc_power = (quot > 30'h0000FFFF) ? 16'hFFFF : quot[15:0];
  endfunction : calc_power

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg, rst_sync_reg, rst_s_n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_s_n = rst_sync_reg;

  // ----------------------------------------------------------------
  // Registers and pipeline state
  // ----------------------------------------------------------------
  logic [15:0] power_reg, power_next;
  logic [15:0] current_reg, current_next;
  logic [15:0] smx_reg, smx_next;
  logic [15:0] smn_reg, smn_next;
  logic [15:0] bmax_reg, bmax_next;
  logic [15:0] bmin_reg, bmin_next;
  logic [15:0] pmx_reg, pmx_next;
  logic [15:0] lsh_reg, lsh_next;
  logic [15:0] lsl_reg, lsl_next;
  logic [15:0] lpr_reg, lpr_next;
  logic [15:0] lbh_reg, lbh_next;
  logic [15:0] lbl_reg, lbl_next;
  logic [15:0] crit_reg, crit_next;
  logic [15:0] cal_reg, cal_next;
  logic [15:0] rd_reg, rd_next;
  logic [15:0] sh1_reg, sh1_next, sh2_reg, sh2_next;
  logic [15:0] bu1_reg, bu1_next, bu2_reg, bu2_next;
  logic        v1_reg, v1_next, v2_reg, v2_next;
  logic [4:0]  flag_reg, flag_next;
  logic [4:0]  cmp_reg, cmp_next;
  logic [4:0]  hit;
  logic        wr_smx, wr_smn, wr_bmax, wr_bmin, wr_pmx;

  // Peak clears fire only on a write with the clear bit set
  always_comb begin
    wr_smx  = reg_wr_en && reg_addr == ADDR_SHUNT_POS_PEAK && reg_wr_data[PEAK_CLEAR_POS];
    wr_smn  = reg_wr_en && reg_addr == ADDR_SHUNT_NEG_PEAK && reg_wr_data[PEAK_CLEAR_POS];
    wr_bmax = reg_wr_en && reg_addr == ADDR_BUS_MAX_PEAK && reg_wr_data[PEAK_CLEAR_POS];
    wr_bmin = reg_wr_en && reg_addr == ADDR_BUS_MIN_PEAK && reg_wr_data[PEAK_CLEAR_POS];
    wr_pmx  = reg_wr_en && reg_addr == ADDR_POWER_PEAK && reg_wr_data[PEAK_CLEAR_POS];
  end

  // ----------------------------------------------------------------
  // Next-state
  // ----------------------------------------------------------------
  always_comb begin
    v1_next      = result_valid;
    v2_next      = v1_reg;
    sh1_next     = result_valid ? shunt_result : sh1_reg;
    bu1_next     = result_valid ? (bus_result & BUS_FIELD_MASK) : bu1_reg;
    current_next = result_valid ? calc_current(shunt_result, cal_reg) : current_reg;
    sh2_next     = v1_reg ? sh1_reg : sh2_reg;
    bu2_next     = v1_reg ? bu1_reg : bu2_reg;
    power_next   = v1_reg ? calc_power(current_reg, bu1_reg) : power_reg;

    // Clear first, then let a same-cycle result overtake the restored value
    smx_next  = wr_smx ? SHUNT_POS_PEAK_POR : smx_reg;
    smn_next  = wr_smn ? SHUNT_NEG_PEAK_POR : smn_reg;
    bmax_next = wr_bmax ? BUS_MAX_PEAK_POR : bmax_reg;
    bmin_next = wr_bmin ? BUS_MIN_PEAK_POR : bmin_reg;
    pmx_next  = wr_pmx ? POWER_PEAK_POR : pmx_reg;
    if (v2_reg) begin
      if ($signed(sh2_reg) > $signed(smx_next)) smx_next = sh2_reg;
      if ($signed(sh2_reg) < $signed(smn_next)) smn_next = sh2_reg;
      if (bu2_reg > bmax_next) bmax_next = bu2_reg;
      if (bu2_reg < bmin_next) bmin_next = bu2_reg;
      if (power_reg > pmx_next) pmx_next = power_reg;
    end

    lsh_next  = lsh_reg;
    lsl_next  = lsl_reg;
    lpr_next  = lpr_reg;
    lbh_next  = lbh_reg;
    lbl_next  = lbl_reg;
    crit_next = crit_reg;
    cal_next  = cal_reg;
    if (reg_wr_en) begin
      unique case (reg_addr)
        ADDR_SHUNT_POS_WARN: lsh_next = reg_wr_data;
        ADDR_SHUNT_NEG_WARN: lsl_next = reg_wr_data;
        ADDR_POWER_WARN:     lpr_next = reg_wr_data;
        ADDR_BUS_HIGH_WARN:  lbh_next = reg_wr_data & BUS_CFG_MASK;
        ADDR_BUS_LOW_WARN:   lbl_next = reg_wr_data & BUS_FIELD_MASK;
        ADDR_CRIT_NEG:       crit_next = reg_wr_data;
        ADDR_CALIBRATION:    cal_next = reg_wr_data;
        default: ;
      endcase
    end

    // Order: shunt high, shunt low, power, bus high, bus low
    hit[0] = $signed(sh2_reg) > $signed(lsh_reg);
    hit[1] = $signed(sh2_reg) < $signed(lsl_reg);
    hit[2] = power_reg > lpr_reg;
    hit[3] = bu2_reg > (lbh_reg & BUS_FIELD_MASK);
    hit[4] = bu2_reg < lbl_reg;
    cmp_next = v2_reg ? hit : cmp_reg;
    // A new hit in the clearing cycle survives the clear
    flag_next = (flag_clear ? 5'h00 : flag_reg) | (v2_reg ? hit : 5'h00);

    rd_next = rd_reg;
    if (reg_rd_en) begin
      unique case (reg_addr)
        ADDR_POWER_RESULT:   rd_next = power_reg;
        ADDR_CURRENT_RESULT: rd_next = current_reg;
        ADDR_SHUNT_POS_PEAK: rd_next = smx_reg;
        ADDR_SHUNT_NEG_PEAK: rd_next = smn_reg;
        ADDR_BUS_MAX_PEAK:   rd_next = bmax_reg;
        ADDR_BUS_MIN_PEAK:   rd_next = bmin_reg;
        ADDR_POWER_PEAK:     rd_next = pmx_reg;
        ADDR_SHUNT_POS_WARN: rd_next = lsh_reg;
        ADDR_SHUNT_NEG_WARN: rd_next = lsl_reg;
        ADDR_POWER_WARN:     rd_next = lpr_reg;
        ADDR_BUS_HIGH_WARN:  rd_next = lbh_reg;
        ADDR_BUS_LOW_WARN:   rd_next = lbl_reg;
        ADDR_CRIT_NEG:       rd_next = crit_reg;
        ADDR_CALIBRATION:    rd_next = cal_reg;
        default:             rd_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      v1_reg      <= 1'b0;
      v2_reg      <= 1'b0;
      sh1_reg     <= 16'h0000;
      sh2_reg     <= 16'h0000;
      bu1_reg     <= 16'h0000;
      bu2_reg     <= 16'h0000;
      current_reg <= 16'h0000;
      power_reg   <= 16'h0000;
      smx_reg     <= SHUNT_POS_PEAK_POR;
      smn_reg     <= SHUNT_NEG_PEAK_POR;
      bmax_reg    <= BUS_MAX_PEAK_POR;
      bmin_reg    <= BUS_MIN_PEAK_POR;
      pmx_reg     <= POWER_PEAK_POR;
      lsh_reg     <= LIMIT_POR;
      lsl_reg     <= LIMIT_POR;
      lpr_reg     <= LIMIT_POR;
      lbh_reg     <= LIMIT_POR;
      lbl_reg     <= LIMIT_POR;
      crit_reg    <= LIMIT_POR;
      cal_reg     <= LIMIT_POR;
      cmp_reg     <= 5'h00;
      flag_reg    <= 5'h00;
      rd_reg      <= 16'h0000;
    end else if (ce) begin
      v1_reg      <= v1_next;
      v2_reg      <= v2_next;
      sh1_reg     <= sh1_next;
      sh2_reg     <= sh2_next;
      bu1_reg     <= bu1_next;
      bu2_reg     <= bu2_next;
      current_reg <= current_next;
      power_reg   <= power_next;
      smx_reg     <= smx_next;
      smn_reg     <= smn_next;
      bmax_reg    <= bmax_next;
      bmin_reg    <= bmin_next;
      pmx_reg     <= pmx_next;
      lsh_reg     <= lsh_next;
      lsl_reg     <= lsl_next;
      lpr_reg     <= lpr_next;
      lbh_reg     <= lbh_next;
      lbl_reg     <= lbl_next;
      crit_reg    <= crit_next;
      cal_reg     <= cal_next;
      cmp_reg     <= cmp_next;
      flag_reg    <= flag_next;
      rd_reg      <= rd_next;
    end
  end

  assign reg_rd_data          = rd_reg;
  assign shunt_high_warn_flag = flag_reg[0];
  assign shunt_low_warn_flag  = flag_reg[1];
  assign power_warn_flag      = flag_reg[2];
  assign bus_high_warn_flag   = flag_reg[3];
  assign bus_low_warn_flag    = flag_reg[4];

  // ----------------------------------------------------------------
  // Warning pin
  // ----------------------------------------------------------------
  // Enable gates only the pin; the flags record regardless
  pmrpw_warn_pin #(
    .TICK_CYCLES (WARN_TICK_CYCLES)
  ) pmrpw_warn_pin_inst (
    .clk         (clk),
    .rst_n       (rst_s_n),
    .ce          (ce),
    .cond        (warn_output_enable && (|cmp_reg)),
    .delay_code  (crit_reg[WARN_DELAY_MSB:0]),
    .latch_en    (lbh_reg[WARN_LATCH_POS]),
    .polarity    (lbh_reg[WARN_POL_POS]),
    .latch_clear (flag_clear),
    .warn_active (),
    .pin_out     (warn_pin_out),
    .pin_oe      (warn_pin_oe)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_s_n);

  a_current_calc: assert property (ce && result_valid |=>
    current_reg == calc_current($past(shunt_result), $past(cal_reg)))
    else $error("current result mismatch");
  a_current_sign: assert property (ce && v1_reg && sh1_reg[15] && cal_reg[15:1] != 15'h0
    |-> current_reg[15] || current_reg == 16'h0000)
    else $error("current sign wrong");
  a_power_calc: assert property (ce && v1_reg |=>
    power_reg == calc_power($past(current_reg), $past(bu1_reg)))
    else $error("power result mismatch");
  a_peak_clear: assert property (ce && wr_smx && !v2_reg |=>
    smx_reg == SHUNT_POS_PEAK_POR)
    else $error("positive peak not cleared");
  a_shunt_max: assert property (ce && v2_reg |=>
    $signed(smx_reg) >= $signed($past(sh2_reg)))
    else $error("positive peak below sample");
  a_shunt_min: assert property (ce && v2_reg |=>
    $signed(smn_reg) <= $signed($past(sh2_reg)))
    else $error("negative peak above sample");
  a_bus_peaks: assert property (ce && v2_reg ##1 1 |->
    bmax_reg >= $past(bu2_reg) && bmin_reg <= $past(bu2_reg) && bmax_reg[2:0] == 3'h0)
    else $error("bus peak wrong");
  a_power_peak: assert property (ce && v2_reg |=> pmx_reg >= $past(power_reg))
    else $error("power peak below sample");
  a_peak_hold: assert property (ce && !v2_reg && !wr_pmx |=>
    pmx_reg == $past(pmx_reg))
    else $error("power peak moved without cause");
  a_shunt_high: assert property (ce && v2_reg && $signed(sh2_reg) > $signed(lsh_reg)
    |=> shunt_high_warn_flag)
    else $error("shunt high flag missed");
  a_shunt_low: assert property (ce && v2_reg && $signed(sh2_reg) < $signed(lsl_reg)
    |=> shunt_low_warn_flag)
    else $error("shunt low flag missed");
  a_power_warn: assert property (ce && v2_reg && power_reg > lpr_reg |=> power_warn_flag)
    else $error("power flag missed");
  a_bus_over: assert property (ce && v2_reg && bu2_reg > (lbh_reg & BUS_FIELD_MASK)
    |=> bus_high_warn_flag)
    else $error("bus over flag missed");
  a_bus_under: assert property (ce && v2_reg && bu2_reg < lbl_reg |=> bus_low_warn_flag)
    else $error("bus under flag missed");
  a_pin_quiet: assert property (!warn_output_enable [*3] |->
    warn_pin_oe == lbh_reg[WARN_POL_POS] || lbh_reg[WARN_LATCH_POS] || $changed(lbh_reg))
    else $error("warning pin active while disabled");
endmodule : pmrpw_bank
`default_nettype wire

/* File: design/pmrpw_pkg.sv */
// Constants for the power monitor result, peak-hold and warning register bank.
// Assumes 16-bit registers addressed by an 8-bit pointer from the serial bus engine.
package pmrpw_pkg;
  // ----------------------------------------------------------------
  // Register pointers
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_POWER_RESULT   = 8'h05;
  localparam logic [7:0] ADDR_CURRENT_RESULT = 8'h06;
  localparam logic [7:0] ADDR_SHUNT_POS_PEAK = 8'h07;
  localparam logic [7:0] ADDR_SHUNT_NEG_PEAK = 8'h08;
  localparam logic [7:0] ADDR_BUS_MAX_PEAK   = 8'h09;
  localparam logic [7:0] ADDR_BUS_MIN_PEAK   = 8'h0A;
  localparam logic [7:0] ADDR_POWER_PEAK     = 8'h0B;
  localparam logic [7:0] ADDR_SHUNT_POS_WARN = 8'h0C;
  localparam logic [7:0] ADDR_SHUNT_NEG_WARN = 8'h0D;
  localparam logic [7:0] ADDR_POWER_WARN     = 8'h0E;
  localparam logic [7:0] ADDR_BUS_HIGH_WARN  = 8'h0F;
  localparam logic [7:0] ADDR_BUS_LOW_WARN   = 8'h10;
  localparam logic [7:0] ADDR_CRIT_NEG       = 8'h15;
  localparam logic [7:0] ADDR_CALIBRATION    = 8'h16;
  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int PEAK_CLEAR_POS   = 0;
  localparam int WARN_LATCH_POS   = 0;
  localparam int WARN_POL_POS     = 1;
  localparam int BUS_FIELD_LSB    = 3;
  localparam int WARN_DELAY_MSB   = 3;
  localparam logic [15:0] BUS_FIELD_MASK = 16'hFFF8;
  localparam logic [15:0] CAL_MASK       = 16'hFFFE;
  localparam logic [15:0] BUS_CFG_MASK   = 16'hFFFB;
  // ----------------------------------------------------------------
  // Power-on values
  // ----------------------------------------------------------------
  localparam logic [15:0] SHUNT_POS_PEAK_POR = 16'h8000;
  localparam logic [15:0] SHUNT_NEG_PEAK_POR = 16'h7FFF;
  localparam logic [15:0] BUS_MAX_PEAK_POR   = 16'h0000;
  localparam logic [15:0] BUS_MIN_PEAK_POR   = 16'hFFF8;
  localparam logic [15:0] POWER_PEAK_POR     = 16'h0000;
  localparam logic [15:0] LIMIT_POR          = 16'h0000;
  // ----------------------------------------------------------------
  // Arithmetic and timing
  // ----------------------------------------------------------------
  localparam int          CURRENT_SHIFT = 12;
  localparam logic [29:0] POWER_DIVISOR = 30'h0001388;
  localparam int          CLK_MHZ       = 125;
  localparam int          WARN_STEP_MS  = 100;
  localparam int          WARN_STEP_CYCLES = WARN_STEP_MS * CLK_MHZ * 1000;
endpackage : pmrpw_pkg

/* File: design/pmrpw_warn_pin.sv */
// Warning pin stage: delay, latch and polarity for the open-collector warning output.
// Assumes a synchronous reset copy and a condition sampled on clk.
`timescale 1ns/1ps
`default_nettype none
module pmrpw_warn_pin
  import pmrpw_pkg::*;
#(
  parameter int TICK_CYCLES = WARN_STEP_CYCLES
) (
  // Clock, reset and enable
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Control
  input  wire logic       cond,
  input  wire logic [3:0] delay_code,
  input  wire logic       latch_en,
  input  wire logic       polarity,
  input  wire logic       latch_clear,
  // Pin side
  output logic            warn_active,
  output logic            pin_out,
  output logic            pin_oe
);
  if (TICK_CYCLES < 1) begin : g_tick_check
    $error("TICK_CYCLES must be at least one");
  end

  logic [31:0] tick_reg, tick_next;
  logic [3:0]  step_reg, step_next;
  logic        act_reg, act_next;
  logic        oe_reg, oe_next;
  logic        timed_out;

  // ----------------------------------------------------------------
  // Delay, latch, polarity
  // ----------------------------------------------------------------
  // Condition must hold for the whole delay; a dropout restarts it
  always_comb begin
    tick_next = tick_reg;
    step_next = step_reg;
    timed_out = cond && (step_reg == delay_code);
    if (!cond) begin
      tick_next = '0;
      step_next = '0;
    end else if (!timed_out) begin
      if (tick_reg == 32'(TICK_CYCLES - 1)) begin
        tick_next = '0;
        step_next = step_reg + 4'h1;
      end else begin
        tick_next = tick_reg + 32'h1;
      end
    end
    if (latch_en) begin
      act_next = timed_out || (act_reg && !latch_clear);
    end else begin
      act_next = timed_out;
    end
    // Low-active pulls the pin down when asserted; high-active releases it
    oe_next = act_next ^ polarity;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_reg <= '0;
      step_reg <= '0;
      act_reg  <= 1'b0;
      oe_reg   <= 1'b0;
    end else if (ce) begin
      tick_reg <= tick_next;
      step_reg <= step_next;
      act_reg  <= act_next;
      oe_reg   <= oe_next;
    end
  end

  assign warn_active = act_reg;
  assign pin_out     = 1'b0;
  assign pin_oe      = oe_reg;
endmodule : pmrpw_warn_pin
`default_nettype wire

/* File: testbench/pmrpw_front_model.sv */
// Behavioural conversion front end that hands new results to the bank.
// Assumes the bank samples result_valid and the data on the rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module pmrpw_front_model (
  // Clock
  input  wire logic        clk,
  // Results
  output logic             result_valid,
  output logic [15:0]      shunt_result,
  output logic [15:0]      bus_result
);
  initial begin
    result_valid = 1'b0;
    shunt_result = 16'h0000;
    bus_result   = 16'h0000;
  end
  // ------------------------------
  // One result
  // ------------------------------
  // Data goes stale after the pulse, so a bank that samples late sees junk
  task automatic convert(input logic [15:0] s, input logic [15:0] b);
    @(negedge clk);
    result_valid <= 1'b1;
    shunt_result <= s;
    bus_result   <= b;
    @(negedge clk);
    result_valid <= 1'b0;
    shunt_result <= ~s;
    bus_result   <= ~b;
  endtask : convert
endmodule : pmrpw_front_model
`default_nettype wire

/* File: testbench/power_monitor_results_peaks_warnings_tb.sv */
// Self-checking bench for the result, peak-hold and warning register bank.
// Assumes the front-end model is compiled first; tick shortened to 4 cycles.
`timescale 1ns/1ps
`default_nettype none
module power_monitor_results_peaks_warnings_tb;
  // ------------------------------
  // Signals and instances
  // ------------------------------
  logic        clk, rst_n, ce, result_valid, reg_wr_en, reg_rd_en;
  logic        warn_en, flag_clear, warn_pin_out, warn_pin_oe;
  logic [15:0] shunt_result, bus_result, reg_wr_data, reg_rd_data;
  logic [7:0]  reg_addr;
  logic [4:0]  flags;
  int          mismatches, comparisons;

  pmrpw_front_model pmrpw_front_model_inst (
    .clk(clk), .result_valid(result_valid),
    .shunt_result(shunt_result), .bus_result(bus_result));

  pmrpw_bank #(.WARN_TICK_CYCLES(4)) pmrpw_bank_inst (
    .clk(clk), .rst_n(rst_n), .ce(ce), .result_valid(result_valid),
    .shunt_result(shunt_result), .bus_result(bus_result),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .warn_output_enable(warn_en), .flag_clear(flag_clear),
    .shunt_high_warn_flag(flags[4]), .shunt_low_warn_flag(flags[3]),
    .power_warn_flag(flags[2]), .bus_high_warn_flag(flags[1]),
    .bus_low_warn_flag(flags[0]),
    .warn_pin_out(warn_pin_out), .warn_pin_oe(warn_pin_oe));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_addr    = a;
    reg_wr_data = d;
    reg_wr_en   = 1'b1;
    @(negedge clk);
    reg_wr_en   = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(negedge clk);
    reg_addr  = a;
    reg_rd_en = 1'b1;
    @(negedge clk);
    reg_rd_en = 1'b0;
    chk(reg_rd_data, exp);
  endtask : rd
  // Pin is looked at a fixed count of cycles on, after its register settles
  task automatic pin(input int n, input logic e);
    repeat (n) @(negedge clk);
    chk({15'h0000, warn_pin_oe}, {15'h0000, e});
  endtask : pin
  task automatic pulse_clear;
    @(negedge clk);
    flag_clear = 1'b1;
    @(negedge clk);
    flag_clear = 1'b0;
  endtask : pulse_clear
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test
  // ------------------------------
  // Tests
  // ------------------------------
  initial begin
    #60000;
    mismatches++;
    end_of_test();
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    reg_addr = 8'h00;
    reg_wr_data = 16'h0000;
    {reg_wr_en, reg_rd_en, warn_en, flag_clear} = 4'h0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    rd(8'h07, 16'h8000);
    rd(8'h08, 16'h7FFF);
    rd(8'h09, 16'h0000);
    rd(8'h0A, 16'hFFF8);
    rd(8'h0B, 16'h0000);
    wr(8'h05, 16'hFFFF);
    rd(8'h05, 16'h0000);
    wr(8'h16, 16'h2000);
    wr(8'h0C, 16'h0032);
    wr(8'h0D, 16'hFFCE);
    wr(8'h0E, 16'h0064);
    wr(8'h0F, 16'hA000);
    wr(8'h10, 16'h9000);
    rd(8'h0D, 16'hFFCE);
    pmrpw_front_model_inst.convert(16'h0064, 16'hC000);
    pin(6, 1'b0);
    chk({11'h000, flags}, 16'h0016);
    chk({15'h0000, warn_pin_out}, 16'h0000);
    rd(8'h06, 16'h00C8);
    rd(8'h05, 16'h00F5);
    pmrpw_front_model_inst.convert(16'hFF9C, 16'h8000);
    repeat (6) @(negedge clk);
    chk({11'h000, flags}, 16'h001F);
    rd(8'h06, 16'hFF38);
    rd(8'h07, 16'h0064);
    rd(8'h08, 16'hFF9C);
    rd(8'h09, 16'hC000);
    rd(8'h0A, 16'h8000);
    rd(8'h0B, 16'h00F5);
    wr(8'h07, 16'h0000);
    rd(8'h07, 16'h0064);
    wr(8'h07, 16'h0001);
    rd(8'h07, 16'h8000);
    wr(8'h0A, 16'h0001);
    rd(8'h0A, 16'hFFF8);
    pulse_clear();
    warn_en = 1'b1;
    pmrpw_front_model_inst.convert(16'h0064, 16'h9C40);
    pin(5, 1'b1);
    wr(8'h0F, 16'hA002);
    pin(3, 1'b0);
    wr(8'h0F, 16'hA000);
    pin(3, 1'b1);
    pmrpw_front_model_inst.convert(16'h0000, 16'h9C40);
    pin(5, 1'b0);
    wr(8'h0F, 16'hA001);
    pmrpw_front_model_inst.convert(16'h0064, 16'h9C40);
    pin(5, 1'b1);
    pmrpw_front_model_inst.convert(16'h0000, 16'h9C40);
    pin(5, 1'b1);
    pulse_clear();
    pin(2, 1'b0);
    wr(8'h0F, 16'hA004);
    rd(8'h0F, 16'hA000);
    wr(8'h15, 16'h0001);
    pmrpw_front_model_inst.convert(16'h0064, 16'h9C40);
    pin(5, 1'b0);
    pin(10, 1'b1);
    // Enable low swallows a result, so no register may move
    ce = 1'b0;
    pmrpw_front_model_inst.convert(16'hFF00, 16'hFFF8);
    ce = 1'b1;
    rd(8'h08, 16'hFF9C);
    rd(8'h09, 16'hC000);
    rd(8'h06, 16'h00C8);
    end_of_test();
  end
endmodule : power_monitor_results_peaks_warnings_tb
`default_nettype wire
